// ===== logic/rx_filter_pkg.sv
// constants, register map and types for the receive address and wake filter
package rx_filter_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0]  OFS_MAC_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_ADDR_LOW      = 8'h04;
    localparam logic [7:0]  OFS_ADDR_HIGH     = 8'h08;
    localparam logic [7:0]  OFS_HASH_LOW      = 8'h0C;
    localparam logic [7:0]  OFS_HASH_HIGH     = 8'h10;
    localparam logic [7:0]  OFS_WAKE_CTRL     = 8'h14;
    localparam logic [7:0]  OFS_WAKE_FILTER   = 8'h18;
    // filter mode control bits
    localparam int          BIT_PASS_ALL_MC   = 0;
    localparam int          BIT_PROMISCUOUS   = 1;
    localparam int          BIT_INVERSE       = 2;
    localparam int          BIT_HASH_ONLY     = 3;
    localparam int          BIT_HASH_PERFECT  = 4;
    localparam int          CTRL_WIDTH        = 5;
    // wake control and status bits
    localparam int          BIT_WAKE_ENABLE   = 0;
    localparam int          BIT_WAKE_RECEIVED = 1;
    localparam int          BIT_EVENT_SELECT  = 2;
    // wake filter command bits
    localparam int          BIT_CMD_ENABLE    = 0;
    localparam int          BIT_CMD_MCAST     = 3;
    localparam int          CMD_STRIDE        = 8;
    localparam int          OFFSET_STRIDE     = 8;
    localparam int          CRC16_STRIDE      = 16;
    // wake filter word layout
    localparam logic [2:0]  WORD_CMD          = 3'h4;
    localparam logic [2:0]  WORD_OFFSET       = 3'h5;
    localparam logic [2:0]  WORD_CRC_LOW      = 3'h6;
    localparam logic [2:0]  WORD_CRC_HIGH     = 3'h7;
    localparam int          FILTER_WORDS      = 8;
    localparam int          NUM_FILTERS       = 4;
    localparam int          MASK_BITS         = 31;
    // reset values
    localparam logic [31:0] RESET_WORD        = 32'h0000_0000;
    localparam logic [CTRL_WIDTH-1:0] RESET_CTRL = 5'h00;
    localparam logic [2:0]  RESET_WAKE_CTRL   = 3'h0;
    // frame layout
    localparam logic [10:0] DA_BYTES          = 11'h006;
    localparam logic [10:0] DA_LAST           = 11'h005;
    localparam logic [10:0] POS_MAX           = 11'h7FF;
    // crc constants
    localparam logic [31:0] HASH_CRC_INIT     = 32'hFFFF_FFFF;
    localparam logic [31:0] HASH_CRC_POLY     = 32'hEDB8_8320;
    localparam logic [15:0] WAKE_CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] WAKE_CRC_POLY     = 16'hA001;

    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DECIDE, ST_BODY} filter_state_type;
endpackage

// ===== logic/dest_hash_crc.sv
// running frame crc over the destination address bytes, feeds the hash index
`timescale 1ns/1ns
`default_nettype none
module dest_hash_crc
    import rx_filter_pkg::*;
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // byte stream
    input  wire logic        i_sof,
    input  wire logic        i_valid,
    input  wire logic [7:0]  i_byte,
    input  wire logic [10:0] i_pos,
    // result
    output logic      [31:0] o_crc
);
    logic [31:0] crc_reg;
    logic [31:0] crc_step;
    logic [31:0] crc_next;

    // lsb-first, reflected polynomial, as on the wire
    always_comb begin
        crc_step = i_sof ? HASH_CRC_INIT : crc_reg;
        for (int k = 0; k < 8; k++) begin
            if (crc_step[0] ^ i_byte[k]) begin
                crc_step = (crc_step >> 1) ^ HASH_CRC_POLY;
            end else begin
                crc_step = crc_step >> 1;
            end
        end
        crc_next = (i_valid && i_pos < DA_BYTES) ? crc_step : crc_reg; // [RQ23]
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            crc_reg <= HASH_CRC_INIT;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign o_crc = crc_reg;
endmodule
`default_nettype wire

// ===== logic/wake_pattern_crc.sv
// crc-16 over the masked pattern bytes of one wake filter
`timescale 1ns/1ns
`default_nettype none
module wake_pattern_crc
    import rx_filter_pkg::*;
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // byte stream
    input  wire logic        i_sof,
    input  wire logic        i_valid,
    input  wire logic [7:0]  i_byte,
    input  wire logic [10:0] i_pos,
    // pattern setup
    input  wire logic [30:0] i_mask,
    input  wire logic [7:0]  i_offset,
    // result
    output logic      [15:0] o_crc
);
    logic [15:0] crc_reg;
    logic [15:0] crc_base;
    logic [15:0] crc_step;
    logic [10:0] rel_pos;
    logic        take_byte;

    // offset counts from the first destination byte
    assign rel_pos   = i_pos - {3'h0, i_offset}; // [RQ22]
    assign take_byte = i_valid && (i_pos >= {3'h0, i_offset})
                       && (rel_pos < 11'(MASK_BITS)) && i_mask[rel_pos[4:0]]; // [RQ16]

    always_comb begin
        crc_base = i_sof ? WAKE_CRC_INIT : crc_reg;
        crc_step = crc_base;
        for (int k = 0; k < 8; k++) begin
            if (crc_step[0] ^ i_byte[k]) begin
                crc_step = (crc_step >> 1) ^ WAKE_CRC_POLY;
            end else begin
                crc_step = crc_step >> 1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            crc_reg <= WAKE_CRC_INIT;
        end else if (take_byte) begin
            crc_reg <= crc_step;
        end else if (i_sof) begin
            crc_reg <= WAKE_CRC_INIT;
        end
    end

    assign o_crc = crc_reg;
endmodule
`default_nettype wire

// ===== logic/rx_address_and_wake_filter.sv
// receive destination address filter and wake-up frame detector
// Function
// (RQ1) perfect mode: accept only when destination equals the station address
// (RQ2) hash-only mode: hash-filter every frame, physical or multicast
// (RQ3) hash index is the upper six bits of the address crc
// (RQ4) 64-bit hash table from high and low words, index msb picks word
// (RQ5) hash-perfect: physical frames perfect-matched, multicast frames hash-filtered
// (RQ6) inverse mode: accept non-matching destinations, reject matching ones
// (RQ7) pass-all-multicast accepts every multicast frame in any mode
// (RQ8) promiscuous accepts every frame including broadcast
// (RQ9) wake enable suspends normal reception and checks wake patterns
// (RQ10) wake detection reported on host interrupt or power event, as selected
// (RQ11) wake detection sets the wake-frame-received status flag
// (RQ12) clearing wake enable returns to normal reception
// (RQ13) software loads patterns and masks before enabling wake detection
// (RQ14) eight successive filter writes fill masks, commands, offsets, crcs in order
// (RQ15) four filters; wake when enabled filter passes address check and crc
// (RQ16) byte mask is bits 30:0; bit j covers byte offset plus j
// (RQ17) software keeps pattern offsets beyond both address fields
// (RQ18) in active power state, wake detection only while wake enable set
// (RQ19) in light sleep, wake detection always on
// (RQ20) command bit 0 enables filter; bit 3 selects multicast or unicast
// (RQ21) programmed pattern crc equal to computed crc is a match
// (RQ22) pattern offset is 8 bits, counted from first destination byte
// (RQ23) hash crc is the ethernet crc over the six destination bytes
// (RQ24) frames failing the address filter are not forwarded
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module rx_address_and_wake_filter
    import rx_filter_pkg::*;
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_write,
    input  wire logic        i_reg_read,
    output logic      [31:0] o_reg_rdata,
    // receive byte stream
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_data,
    input  wire logic        i_rx_sof,
    input  wire logic        i_rx_eof,
    // power state
    input  wire logic        i_light_sleep_state,
    // frame decision
    output logic             o_frame_decided,
    output logic             o_frame_accept,
    // wake reporting
    output logic             o_host_irq,
    output logic             o_power_event_out
);
    filter_state_type        state_reg;
    filter_state_type        state_next;
    logic [10:0]             pos_reg;
    logic [10:0]             byte_pos;
    logic [47:0]             dest_reg;
    logic [CTRL_WIDTH-1:0]   ctrl_reg;
    logic [31:0]             addr_low_reg;
    logic [15:0]             addr_high_reg;
    logic [31:0]             hash_low_reg;
    logic [31:0]             hash_high_reg;
    logic [2:0]              wake_ctrl_reg;
    logic [31:0]             wake_words [FILTER_WORDS];
    logic [2:0]              wake_ptr_reg;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic                    addr_pass_reg;
    logic                    addr_pass_next;
    logic                    decided_reg;
    logic [31:0]             hash_crc;
    logic [5:0]              hash_index;
    logic [63:0]             hash_table;
    logic                    hash_hit;
    logic                    perfect_hit;
    logic                    dest_mcast;
    logic                    wake_active;
    logic [NUM_FILTERS-1:0]  filter_hit;
    logic                    wake_hit;
    logic                    pass_all_mc;
    logic                    promiscuous_enable;
    logic                    inverse_filter_enable;
    logic                    hash_only_select;
    logic                    hash_perfect_select;
    logic                    wake_frame_enable;
    logic                    wake_frame_received;
    logic                    power_event_select;
    logic                    wake_ctrl_write;
    logic                    filter_write;
    logic                    filter_read;

    assign pass_all_mc           = ctrl_reg[BIT_PASS_ALL_MC];
    assign promiscuous_enable    = ctrl_reg[BIT_PROMISCUOUS];
    assign inverse_filter_enable = ctrl_reg[BIT_INVERSE];
    assign hash_only_select      = ctrl_reg[BIT_HASH_ONLY];
    assign hash_perfect_select   = ctrl_reg[BIT_HASH_PERFECT];
    assign wake_frame_enable     = wake_ctrl_reg[BIT_WAKE_ENABLE];
    assign wake_frame_received   = wake_ctrl_reg[BIT_WAKE_RECEIVED];
    assign power_event_select    = wake_ctrl_reg[BIT_EVENT_SELECT];
    assign wake_ctrl_write       = i_reg_write && i_reg_addr == OFS_WAKE_CTRL;
    assign filter_write          = i_reg_write && i_reg_addr == OFS_WAKE_FILTER;
    assign filter_read           = i_reg_read && i_reg_addr == OFS_WAKE_FILTER;

    // light sleep cannot switch detection off
    assign wake_active = i_light_sleep_state || wake_frame_enable; // [RQ18] [RQ19]

    // software registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ctrl_reg      <= RESET_CTRL;
            addr_low_reg  <= RESET_WORD;
            addr_high_reg <= RESET_WORD[15:0];
            hash_low_reg  <= RESET_WORD;
            hash_high_reg <= RESET_WORD;
        end else if (i_reg_write) begin
            unique case (i_reg_addr)
                OFS_MAC_CTRL:  ctrl_reg      <= i_reg_wdata[CTRL_WIDTH-1:0];
                OFS_ADDR_LOW:  addr_low_reg  <= i_reg_wdata;
                OFS_ADDR_HIGH: addr_high_reg <= i_reg_wdata[15:0];
                OFS_HASH_LOW:  hash_low_reg  <= i_reg_wdata;
                OFS_HASH_HIGH: hash_high_reg <= i_reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // wake control and status; detection beats a clear in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wake_ctrl_reg <= RESET_WAKE_CTRL;
        end else begin
            if (wake_ctrl_write) begin
                wake_ctrl_reg[BIT_WAKE_ENABLE]  <= i_reg_wdata[BIT_WAKE_ENABLE]; // [RQ12]
                wake_ctrl_reg[BIT_EVENT_SELECT] <= i_reg_wdata[BIT_EVENT_SELECT];
            end
            if (wake_hit) begin
                wake_ctrl_reg[BIT_WAKE_RECEIVED] <= 1'b1; // [RQ11]
            end else if (wake_ctrl_write && i_reg_wdata[BIT_WAKE_RECEIVED]) begin
                wake_ctrl_reg[BIT_WAKE_RECEIVED] <= 1'b0;
            end
        end
    end

    // filter words fill in order; pointer wraps after the eighth
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wake_ptr_reg <= 3'h0;
            for (int w = 0; w < FILTER_WORDS; w++) begin
                wake_words[w] <= RESET_WORD;
            end
        end else begin
            if (filter_write) begin
                wake_words[wake_ptr_reg] <= i_reg_wdata; // [RQ14]
            end
            if (wake_ctrl_write) begin
                wake_ptr_reg <= 3'h0;
            end else if (filter_write || filter_read) begin
                wake_ptr_reg <= wake_ptr_reg + 3'h1; // [RQ14]
            end
        end
    end

    // read data, valid the cycle after the strobe only
    always_comb begin
        rdata_next = RESET_WORD;
        if (i_reg_read) begin
            unique case (i_reg_addr)
                OFS_MAC_CTRL:    rdata_next = {27'h0, ctrl_reg};
                OFS_ADDR_LOW:    rdata_next = addr_low_reg;
                OFS_ADDR_HIGH:   rdata_next = {16'h0, addr_high_reg};
                OFS_HASH_LOW:    rdata_next = hash_low_reg;
                OFS_HASH_HIGH:   rdata_next = hash_high_reg;
                OFS_WAKE_CTRL:   rdata_next = {29'h0, wake_ctrl_reg};
                OFS_WAKE_FILTER: rdata_next = wake_words[wake_ptr_reg];
                default:         rdata_next = RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_reg <= RESET_WORD;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_reg_rdata = rdata_reg;

    // byte position, restarted by the first byte of each frame
    assign byte_pos = i_rx_sof ? 11'h000 : pos_reg; // [RQ22]

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pos_reg <= 11'h000;
        end else if (i_rx_valid && byte_pos != POS_MAX) begin
            pos_reg <= byte_pos + 11'h001;
        end
    end

    // destination bytes, first received byte in the low lane
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            dest_reg <= 48'h0;
        end else if (i_rx_valid && byte_pos < DA_BYTES) begin
            dest_reg[byte_pos[2:0]*8 +: 8] <= i_rx_data;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:   if (i_rx_valid && i_rx_sof) state_next = ST_ADDR;
            ST_ADDR: begin
                if (i_rx_eof) begin
                    state_next = ST_IDLE;
                end else if (i_rx_valid && byte_pos == DA_LAST) begin
                    state_next = ST_DECIDE;
                end
            end
            ST_DECIDE: state_next = i_rx_eof ? ST_IDLE : ST_BODY;
            ST_BODY:   if (i_rx_eof) state_next = ST_IDLE;
        endcase
        // a new frame start always resynchronises
        if (i_rx_valid && i_rx_sof && state_reg != ST_IDLE) begin
            state_next = ST_ADDR;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    dest_hash_crc u_hash_crc (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_sof     (i_rx_sof),
        .i_valid   (i_rx_valid),
        .i_byte    (i_rx_data),
        .i_pos     (byte_pos),
        .o_crc     (hash_crc)
    );

    // address checks
    assign hash_index  = hash_crc[31:26]; // [RQ3]
    assign hash_table  = {hash_high_reg, hash_low_reg}; // [RQ4]
    assign hash_hit    = hash_table[hash_index]; // [RQ4]
    assign perfect_hit = dest_reg == {addr_high_reg, addr_low_reg}; // [RQ1]
    assign dest_mcast  = dest_reg[0];

    always_comb begin
        if (promiscuous_enable) begin
            addr_pass_next = 1'b1; // [RQ8]
        end else if (pass_all_mc && dest_mcast) begin
            addr_pass_next = 1'b1; // [RQ7]
        end else if (hash_only_select) begin
            addr_pass_next = hash_hit; // [RQ2]
        end else if (hash_perfect_select) begin
            addr_pass_next = dest_mcast ? hash_hit : perfect_hit; // [RQ5]
        end else if (inverse_filter_enable) begin
            addr_pass_next = !perfect_hit; // [RQ6]
        end else begin
            addr_pass_next = perfect_hit; // [RQ1]
        end
    end

    // decision lives from the cycle after the decide state until the next frame start
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            addr_pass_reg <= 1'b0;
            decided_reg   <= 1'b0;
        end else begin
            decided_reg <= state_reg == ST_DECIDE;
            if (state_reg == ST_DECIDE) begin
                addr_pass_reg <= addr_pass_next;
            end else if (i_rx_valid && i_rx_sof) begin
                addr_pass_reg <= 1'b0;
            end
        end
    end

    assign o_frame_decided = decided_reg;
    // failing frames and all frames in wake mode are dropped
    assign o_frame_accept  = addr_pass_reg && !wake_active; // [RQ9] [RQ24]

    // four pattern filters
    generate
        for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filter
            logic [15:0] calc_crc;
            logic [15:0] want_crc;
            logic [7:0]  command;
            wake_pattern_crc u_pattern (
                .i_sys_clk (i_sys_clk),
                .i_rst     (i_rst),
                .i_sof     (i_rx_sof),
                .i_valid   (i_rx_valid),
                .i_byte    (i_rx_data),
                .i_pos     (byte_pos),
                .i_mask    (wake_words[f][30:0]),
                .i_offset  (wake_words[WORD_OFFSET][f*OFFSET_STRIDE +: 8]),
                .o_crc     (calc_crc)
            );
            assign command  = wake_words[WORD_CMD][f*CMD_STRIDE +: 8];
            assign want_crc = wake_words[WORD_CRC_LOW + 3'(f/2)][(f%2)*CRC16_STRIDE +: 16];
            assign filter_hit[f] = command[BIT_CMD_ENABLE]                    // [RQ20]
                                   && (command[BIT_CMD_MCAST] == dest_mcast) // [RQ20]
                                   && calc_crc == want_crc;                  // [RQ21]
        end
    endgenerate

    // frames that reached the decision and passed the address check
    assign wake_hit = wake_active && i_rx_eof && state_reg == ST_BODY
                      && addr_pass_reg && |filter_hit; // [RQ15]

    // report on the selected output
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_host_irq        <= 1'b0;
            o_power_event_out <= 1'b0;
        end else begin
            o_host_irq        <= wake_frame_received && !power_event_select; // [RQ10]
            o_power_event_out <= wake_frame_received && power_event_select;  // [RQ10]
        end
    end

    // checks
    sequence s_addr_done;
        (state_reg == ST_ADDR && i_rx_valid && !i_rx_sof && byte_pos == DA_LAST && !i_rx_eof)
        ##1 (state_reg == ST_DECIDE);
    endsequence

    property p_promisc;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_addr_done ##0 promiscuous_enable |=> addr_pass_reg && o_frame_decided;
    endproperty
    a_promisc: assert property (p_promisc) else $error("promiscuous frame rejected"); // [RQ8]

    property p_pass_mc;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_addr_done ##0 (pass_all_mc && dest_mcast) |=> addr_pass_reg;
    endproperty
    a_pass_mc: assert property (p_pass_mc) else $error("multicast not passed"); // [RQ7]

    property p_perfect;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_addr_done ##0 (ctrl_reg == RESET_CTRL) |=> addr_pass_reg == $past(perfect_hit);
    endproperty
    a_perfect: assert property (p_perfect) else $error("perfect filter wrong"); // [RQ1]

    property p_inverse;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_addr_done ##0 (ctrl_reg == 5'h04) |=> addr_pass_reg != $past(perfect_hit);
    endproperty
    a_inverse: assert property (p_inverse) else $error("inverse filter wrong"); // [RQ6]

    property p_hash_only;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_addr_done ##0 (ctrl_reg == 5'h08)
        |=> addr_pass_reg == $past(hash_table[hash_crc[31:26]]);
    endproperty
    a_hash_only: assert property (p_hash_only) else $error("hash filter wrong"); // [RQ2]

    property p_hash_perfect_phys;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_addr_done ##0 (ctrl_reg == 5'h10 && !dest_mcast)
        |=> addr_pass_reg == $past(perfect_hit);
    endproperty
    a_hash_perfect_phys: assert property (p_hash_perfect_phys) else $error("hash-perfect wrong"); // [RQ5]

    property p_wake_blocks;
        @(posedge i_sys_clk) disable iff (i_rst)
        wake_active |-> !o_frame_accept;
    endproperty
    a_wake_blocks: assert property (p_wake_blocks) else $error("frame accepted in wake mode"); // [RQ9]

    property p_wake_flag;
        @(posedge i_sys_clk) disable iff (i_rst)
        wake_hit |=> wake_frame_received ##1 (o_host_irq != o_power_event_out);
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake not reported"); // [RQ11]

    property p_report_select;
        @(posedge i_sys_clk) disable iff (i_rst)
        (wake_frame_received && power_event_select) [*2] |-> o_power_event_out && !o_host_irq;
    endproperty
    a_report_select: assert property (p_report_select) else $error("wrong wake output"); // [RQ10]

    property p_eight_writes;
        @(posedge i_sys_clk) disable iff (i_rst)
        (wake_ptr_reg == 3'h7 && filter_write && !wake_ctrl_write) |=> wake_ptr_reg == 3'h0;
    endproperty
    a_eight_writes: assert property (p_eight_writes) else $error("filter pointer no wrap"); // [RQ14]
endmodule
`default_nettype wire

// ===== verif/rx_frame_source.sv
// receive datapath model that streams one frame into the filter
`timescale 1ns/1ns
`default_nettype none
module rx_frame_source (
    // clock
    input  wire logic  i_sys_clk,
    // byte stream
    output logic       o_valid = 1'h0,
    output logic [7:0] o_data = 8'h00,
    output logic       o_sof = 1'h0,
    output logic       o_eof = 1'h0
);
    task automatic send(input logic [47:0] da, input int len);
        for (int i = 0; i < len; i++) begin
            @(posedge i_sys_clk);
            o_valid <= 1'h1;
            o_sof <= (i == 0);
            o_data <= (i < 6) ? da[47 - 8*i -: 8] : 8'(i);
        end
        @(posedge i_sys_clk);
        o_valid <= 1'h0;
        o_data <= ~o_data;  // stale byte must not look valid
        o_eof <= 1'h1;
        @(posedge i_sys_clk);
        o_eof <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ===== verif/test_rx_address_and_wake_filter.sv
// self-checking bench for the receive address and wake filter
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module test_rx_address_and_wake_filter import rx_filter_pkg::*; ;
    localparam logic [47:0] ST = 48'h021122334455, OT = 48'h021122334456, BC = '1, MC = 48'h01005E000001;
    logic        clk = 1'h0, rst = 1'h1, we = 1'h0, re = 1'h0, sleep = 1'h0;
    logic [7:0]  addr = 8'h00, data;
    logic [31:0] wdata = 32'h0, rdata;
    logic        valid, sof, eof, dec, acc, irq, power_event_out, last_acc;
    int          fails = 0, checked = 0;
    logic [54:0] rows [12] = '{{5'h00,1'h0,ST,1'h1}, {5'h00,1'h0,OT,1'h0}, {5'h00,1'h0,BC,1'h0},
        {5'h04,1'h0,ST,1'h0}, {5'h04,1'h0,OT,1'h1}, {5'h02,1'h0,BC,1'h1}, {5'h01,1'h0,MC,1'h1},
        {5'h08,1'h1,OT,1'h1}, {5'h08,1'h0,ST,1'h0}, {5'h10,1'h1,MC,1'h1}, {5'h10,1'h0,MC,1'h0},
        {5'h10,1'h0,ST,1'h1}};
    logic [31:0] fw [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'hC, 32'hFFFF, 32'h0};
    always #5 clk = ~clk;
    always @(posedge clk) if (dec === 1'h1) last_acc <= acc;
    rx_address_and_wake_filter u_dut (.i_sys_clk(clk), .i_rst(rst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_write(we), .i_reg_read(re), .o_reg_rdata(rdata),
        .i_rx_valid(valid), .i_rx_data(data), .i_rx_sof(sof), .i_rx_eof(eof),
        .i_light_sleep_state(sleep), .o_frame_decided(dec), .o_frame_accept(acc),
        .o_host_irq(irq), .o_power_event_out(power_event_out));
    rx_frame_source u_src (.i_sys_clk(clk), .o_valid(valid), .o_data(data), .o_sof(sof),
        .o_eof(eof));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= w;
        re <= !w;
        @(posedge clk);
        we <= 1'h0;
        re <= 1'h0;
        if (!w) @(negedge clk);
        if (!w) `CHK("rdata", d, rdata)
    endtask
    task automatic end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        bus(1'h0, OFS_MAC_CTRL, 32'h0);
        bus(1'h0, 8'hFC, 32'h0);
        bus(1'h1, OFS_ADDR_LOW, 32'h33221102);
        bus(1'h1, OFS_ADDR_HIGH, 32'h00005544);
        foreach (rows[k]) begin
            bus(1'h1, OFS_MAC_CTRL, {27'h0, rows[k][54:50]});
            bus(1'h1, OFS_HASH_LOW, {32{rows[k][49]}});
            bus(1'h1, OFS_HASH_HIGH, {32{rows[k][49]}});
            u_src.send(rows[k][48:1], 20);
            `CHK("accept", rows[k][0], last_acc)
        end
        foreach (fw[k]) bus(1'h1, OFS_WAKE_FILTER, fw[k]);
        bus(1'h1, OFS_WAKE_CTRL, 32'h0);
        foreach (fw[k]) bus(1'h0, OFS_WAKE_FILTER, fw[k]);
        bus(1'h1, OFS_WAKE_CTRL, 32'h1);
        u_src.send(ST, 20);
        repeat (3) @(negedge clk);
        `CHK("accept", 1'h0, last_acc)
        `CHK("irq", 1'h1, irq)
        `CHK("pme", 1'h0, power_event_out)
        bus(1'h0, OFS_WAKE_CTRL, 32'h3);
        bus(1'h1, OFS_WAKE_CTRL, 32'h6);
        u_src.send(ST, 20);
        `CHK("accept", 1'h1, last_acc)
        sleep <= 1'h1;
        u_src.send(ST, 20);
        repeat (3) @(negedge clk);
        `CHK("pme", 1'h1, power_event_out)
        end_of_test;
    end
endmodule
`default_nettype wire
